// ---- gos_pkg.sv ----
// Constants, enumerations and carriers of the gyro output sequencer
package gos_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Internal sampling at 2000 samples/s
    localparam int unsigned SMP_PERIOD_NS = 500_000;
    localparam int unsigned SMP_CYC = SMP_PERIOD_NS / CLK_PERIOD_NS;
    // Reference settle time and gyro start-up period
    localparam int unsigned SETTLE_US = 100;
    localparam int unsigned SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_MS = 100;
    localparam int unsigned STARTUP_CYC =
        (STARTUP_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Register map and fields
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_CNT = 8'h0C;
    localparam int unsigned CTRL_RESET_BIT = 0;
    localparam int unsigned CTRL_SVC_BIT = 1;
    localparam int unsigned CTRL_EXIT_INIT_BIT = 2;
    localparam int unsigned CTRL_EXIT_NORM_BIT = 3;
    localparam int unsigned CFG_UNIT_LSB = 0;
    localparam int unsigned CFG_TRIG_BIT = 2;
    localparam int unsigned CFG_DIV_LSB = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0004 << 0 | 32'h0000_0800;
    localparam int unsigned ST_STARTUP_BIT = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Datagram lengths in bytes
    // ****************************************
    localparam logic [7:0] LEN_MEAS = 8'h0A;
    localparam logic [7:0] LEN_PART = 8'h10;
    localparam logic [7:0] LEN_SERIAL = 8'h10;
    localparam logic [7:0] LEN_CONFIG = 8'h15;

    // ****************************************
    // Arithmetic
    // ****************************************
    // Rate counts times 8/125 give angle counts per internal sample
    localparam int signed ANG_NUM = 8;
    localparam int signed ANG_DEN = 125;
    localparam int unsigned LP_SHIFT = 3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {UNIT_RATE, UNIT_INC, UNIT_AVG, UNIT_INT} gos_unit_t;
    typedef enum logic [2:0] {MODE_SETTLE, MODE_SYNC, MODE_SPECIAL, MODE_NORMAL, MODE_SERVICE}
        gos_mode_t;
    typedef enum logic [1:0] {KIND_MEAS, KIND_PART, KIND_SERIAL, KIND_CONFIG} gos_kind_t;

    // One internal sample of all three channels
    typedef struct packed {
        logic [2:0][23:0] rate;
        logic [2:0][15:0] temp;
        logic [7:0] flags;
    } gos_sample_t;

    // Datagram fields, most significant byte of each field first
    typedef struct packed {
        gos_kind_t kind;
        logic [7:0] len;
        logic [2:0][23:0] value;
        logic [2:0][15:0] temp;
        logic [7:0] status;
        logic [7:0] counter;
    } gos_dgram_t;
endpackage : gos_pkg

// ---- gos_top.sv ----
// Gyro output sequencer: modes, validity strobe, decimation and output quantities
`timescale 1ns/100ps
module gos_top #(
    parameter int unsigned SMP_CYC_P = gos_pkg::SMP_CYC,
    parameter int unsigned SETTLE_CYC_P = gos_pkg::SETTLE_CYC,
    parameter int unsigned STARTUP_CYC_P = gos_pkg::STARTUP_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [gos_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gos_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic external_reset_n,
    input wire logic sample_request_input,
    output logic validity_strobe,
    // Sensor channels
    input wire gos_pkg::gos_sample_t sample_in,
    output logic sample_strobe,
    output logic chan_sync,
    // Datagram transmitter
    output logic dgram_start,
    output gos_pkg::gos_dgram_t dgram,
    input wire logic tx_last_bit_done
);
    // ****************************************
    // Declarations
    // ****************************************
    logic aw_rdy_q, w_rdy_q, b_vld_q, ar_rdy_q, r_vld_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, cfg_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic rst_s1_q, rst_s2_q, trg_s1_q, trg_s2_q, trg_s3_q;
    logic [15:0] smp_cnt_q;
    logic smp_tick_q, out_due_q, strobe_q, start_q, sync_q, spec_busy_q, startup_q;
    logic [7:0] dec_cnt_q, n_q, free_cnt_q;
    logic [1:0] spec_idx_q;
    logic [31:0] tmr_q;
    gos_pkg::gos_mode_t mode_q, mode_d;
    gos_pkg::gos_dgram_t dgram_q;
    gos_pkg::gos_sample_t smp_q;
    logic [2:0][23:0] val_w;

    // Register decode shared by the write and read paths
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : reg_hit

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Length of each datagram kind
    function automatic logic [7:0] kind_len(input gos_pkg::gos_kind_t k);
        unique case (k)
            gos_pkg::KIND_MEAS: return gos_pkg::LEN_MEAS;
            gos_pkg::KIND_PART: return gos_pkg::LEN_PART;
            gos_pkg::KIND_SERIAL: return gos_pkg::LEN_SERIAL;
            gos_pkg::KIND_CONFIG: return gos_pkg::LEN_CONFIG;
        endcase
    endfunction : kind_len

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    wire wr_fire = !aw_rdy_q && !w_rdy_q && !b_vld_q;
    wire wr_ctrl = wr_fire && reg_hit(awaddr_q, gos_pkg::REG_CTRL) && wstrb_q[0];
    wire wr_cfg = wr_fire && reg_hit(awaddr_q, gos_pkg::REG_CFG);
    wire wr_map = reg_hit(awaddr_q, gos_pkg::REG_CTRL) || reg_hit(awaddr_q, gos_pkg::REG_CFG);
    wire rd_map = reg_hit(s_axi_araddr, gos_pkg::REG_CTRL)
                  || reg_hit(s_axi_araddr, gos_pkg::REG_CFG)
                  || reg_hit(s_axi_araddr, gos_pkg::REG_STAT)
                  || reg_hit(s_axi_araddr, gos_pkg::REG_CNT);
    wire [7:0] dgram_status_w;
    wire [31:0] stat_w = {16'h0000, dgram_status_w, 5'h00, mode_q};
    wire [31:0] rd_w = reg_hit(s_axi_araddr, gos_pkg::REG_CFG) ? cfg_q
                       : reg_hit(s_axi_araddr, gos_pkg::REG_STAT) ? stat_w
                       : reg_hit(s_axi_araddr, gos_pkg::REG_CNT) ? {16'h0000, free_cnt_q, n_q}
                       : 32'h0000_0000;

    // Write address and data are taken in either order, answered once both are in
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
            b_vld_q <= 1'b0;
            bresp_q <= gos_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && aw_rdy_q) aw_rdy_q <= 1'b0;
            if (s_axi_wvalid && w_rdy_q) w_rdy_q <= 1'b0;
            if (wr_fire) begin
                b_vld_q <= 1'b1;
                bresp_q <= wr_map ? gos_pkg::RESP_OKAY : gos_pkg::RESP_SLVERR;
            end
            if (b_vld_q && s_axi_bready) begin
                b_vld_q <= 1'b0;
                aw_rdy_q <= 1'b1;
                w_rdy_q <= 1'b1;
            end
        end
    end

    // Write payload capture
    always_ff @(posedge clk_sys) begin
        if (s_axi_awvalid && aw_rdy_q) awaddr_q <= s_axi_awaddr;
        if (s_axi_wvalid && w_rdy_q) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ar_rdy_q <= 1'b1;
            r_vld_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= gos_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && ar_rdy_q) begin
            ar_rdy_q <= 1'b0;
            r_vld_q <= 1'b1;
            rdata_q <= rd_w;
            rresp_q <= rd_map ? gos_pkg::RESP_OKAY : gos_pkg::RESP_SLVERR;
        end else if (r_vld_q && s_axi_rready) begin
            ar_rdy_q <= 1'b1;
            r_vld_q <= 1'b0;
        end
    end

    // Configuration register
    always_ff @(posedge clk_sys) begin
        if (rst) cfg_q <= gos_pkg::CFG_RESET;
        else if (wr_cfg) cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
    end

    // ****************************************
    // Pin synchronisers and sample timebase
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {rst_s1_q, rst_s2_q} <= 2'h3;
            {trg_s1_q, trg_s2_q, trg_s3_q} <= 3'h7;
        end else begin
            {rst_s1_q, rst_s2_q} <= {external_reset_n, rst_s1_q};
            {trg_s1_q, trg_s2_q, trg_s3_q} <= {sample_request_input, trg_s1_q, trg_s2_q};
        end
    end

    wire [1:0] unit_w = cfg_q[gos_pkg::CFG_UNIT_LSB +: 2];
    wire trig_mode = cfg_q[gos_pkg::CFG_TRIG_BIT];
    wire [7:0] div_w = cfg_q[gos_pkg::CFG_DIV_LSB +: 8];
    wire [7:0] div_eff = (div_w == 8'h00) ? 8'h01 : div_w;
    wire trig_fall = trg_s3_q && !trg_s2_q;
    wire smp_end = smp_cnt_q == 16'(SMP_CYC_P - 1);

    // 2000 samples/s tick and decimation to the output rate
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            smp_cnt_q <= 16'h0000;
            smp_tick_q <= 1'b0;
            dec_cnt_q <= 8'h00;
            out_due_q <= 1'b0;
        end else begin
            smp_cnt_q <= smp_end ? 16'h0000 : smp_cnt_q + 16'h0001;
            smp_tick_q <= smp_end;
            out_due_q <= smp_tick_q && dec_cnt_q == div_eff - 8'h01;
            if (smp_tick_q) dec_cnt_q <= (dec_cnt_q >= div_eff - 8'h01) ? 8'h00 : dec_cnt_q + 8'h01;
        end
    end

    // ****************************************
    // Mode controller
    // ****************************************
    wire cmd_reset = wr_ctrl && wdata_q[gos_pkg::CTRL_RESET_BIT];
    wire cmd_svc = wr_ctrl && wdata_q[gos_pkg::CTRL_SVC_BIT];
    wire cmd_exit_init = wr_ctrl && wdata_q[gos_pkg::CTRL_EXIT_INIT_BIT];
    wire cmd_exit_norm = wr_ctrl && wdata_q[gos_pkg::CTRL_EXIT_NORM_BIT];
    wire init_req = !rst_s2_q
                    || (mode_q == gos_pkg::MODE_NORMAL && cmd_reset)
                    || (mode_q == gos_pkg::MODE_SERVICE && cmd_exit_init);
    wire spec_done = spec_busy_q && tx_last_bit_done;
    wire spec_start = mode_q == gos_pkg::MODE_SPECIAL && !spec_busy_q && !init_req;
    wire is_normal = mode_q == gos_pkg::MODE_NORMAL;
    wire xmit = is_normal && (trig_mode ? trig_fall : out_due_q);

    // Next mode
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            gos_pkg::MODE_SETTLE: if (tmr_q == 32'(SETTLE_CYC_P - 1)) mode_d = gos_pkg::MODE_SYNC;
            gos_pkg::MODE_SYNC: mode_d = gos_pkg::MODE_SPECIAL;
            gos_pkg::MODE_SPECIAL: if (spec_done && spec_idx_q == 2'h2) mode_d = gos_pkg::MODE_NORMAL;
            gos_pkg::MODE_NORMAL: if (cmd_svc) mode_d = gos_pkg::MODE_SERVICE;
            gos_pkg::MODE_SERVICE: if (cmd_exit_norm) mode_d = gos_pkg::MODE_NORMAL;
            default: mode_d = gos_pkg::MODE_SETTLE;
        endcase
        if (init_req) mode_d = gos_pkg::MODE_SETTLE;
    end

    // Mode register, timer and special datagram sequence
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_q <= gos_pkg::MODE_SETTLE;
            tmr_q <= 32'h0000_0000;
            spec_idx_q <= 2'h0;
            spec_busy_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            tmr_q <= (mode_d != mode_q || init_req) ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
            if (mode_q != gos_pkg::MODE_SPECIAL) spec_idx_q <= 2'h0;
            else if (spec_done) spec_idx_q <= spec_idx_q + 2'h1;
            if (init_req || spec_done) spec_busy_q <= 1'b0;
            else if (spec_start) spec_busy_q <= 1'b1;
        end
    end

    // Start-up flag: set on entry from init, never on return from service
    always_ff @(posedge clk_sys) begin
        if (rst || init_req) startup_q <= 1'b0;
        else if (mode_q == gos_pkg::MODE_SPECIAL && mode_d == gos_pkg::MODE_NORMAL) startup_q <= 1'b1;
        else if (mode_q == gos_pkg::MODE_SERVICE && mode_d == gos_pkg::MODE_NORMAL) startup_q <= 1'b0;
        else if (is_normal && tmr_q == 32'(STARTUP_CYC_P - 1)) startup_q <= 1'b0;
    end

    // ****************************************
    // Output quantities per axis
    // ****************************************
    wire clr = xmit || mode_q == gos_pkg::MODE_SYNC;

    // Latest sample and sample counters
    always_ff @(posedge clk_sys) begin
        if (rst || mode_q == gos_pkg::MODE_SYNC) begin
            smp_q <= '0;
            n_q <= 8'h00;
            free_cnt_q <= 8'h00;
        end else begin
            if (smp_tick_q) smp_q <= sample_in;
            if (smp_tick_q) free_cnt_q <= free_cnt_q + 8'h01;
            if (xmit) n_q <= {7'h00, smp_tick_q};
            else if (smp_tick_q && n_q != 8'hFF) n_q <= n_q + 8'h01;
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_axis
        logic signed [31:0] rem_q, inc_q, lp_q, sum_q;
        logic [23:0] int_q;
        wire signed [31:0] rate_w = 32'($signed(sample_in.rate[g]));
        wire signed [31:0] step_w = rate_w * gos_pkg::ANG_NUM + rem_q;
        wire signed [31:0] quo_w = step_w / gos_pkg::ANG_DEN;
        wire signed [31:0] lp_w = lp_q + ((rate_w - lp_q) >>> gos_pkg::LP_SHIFT);
        wire signed [31:0] avg_w = (n_q == 8'h00) ? lp_q : sum_q / $signed({24'h00_0000, n_q});
        // Angle integration with exact remainder carry, low-pass and running sum
        always_ff @(posedge clk_sys) begin
            if (rst || mode_q == gos_pkg::MODE_SYNC) begin
                {rem_q, inc_q, lp_q, sum_q} <= '0;
                int_q <= 24'h00_0000;
            end else begin
                if (smp_tick_q) rem_q <= step_w - quo_w * gos_pkg::ANG_DEN;
                if (smp_tick_q) int_q <= int_q + quo_w[23:0];
                if (smp_tick_q) lp_q <= lp_w;
                inc_q <= (clr ? 32'sh0000_0000 : inc_q) + (smp_tick_q ? quo_w : 32'sh0000_0000);
                sum_q <= (clr ? 32'sh0000_0000 : sum_q) + (smp_tick_q ? lp_w : 32'sh0000_0000);
            end
        end
        // Selected output quantity
        assign val_w[g] = (unit_w == gos_pkg::UNIT_RATE) ? smp_q.rate[g]
                          : (unit_w == gos_pkg::UNIT_INC) ? inc_q[23:0]
                          : (unit_w == gos_pkg::UNIT_AVG) ? avg_w[23:0]
                          : int_q;
    end

    // Status byte: sensor flags with the start-up bit taken from the mode controller
    assign dgram_status_w = {smp_q.flags[7], startup_q, smp_q.flags[5:0]};
    wire count_mode = unit_w == gos_pkg::UNIT_INC || unit_w == gos_pkg::UNIT_AVG;

    // ****************************************
    // Datagram hand-off and validity strobe
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_q <= 1'b0;
            dgram_q <= '0;
        end else begin
            start_q <= spec_start || xmit;
            if (spec_start) begin
                dgram_q <= '0;
                dgram_q.kind <= gos_pkg::gos_kind_t'(spec_idx_q + 2'h1);
                dgram_q.len <= kind_len(gos_pkg::gos_kind_t'(spec_idx_q + 2'h1));
            end else if (xmit) begin
                dgram_q.kind <= gos_pkg::KIND_MEAS;
                dgram_q.len <= kind_len(gos_pkg::KIND_MEAS);
                dgram_q.value <= val_w;
                dgram_q.temp <= smp_q.temp;
                dgram_q.status <= dgram_status_w;
                dgram_q.counter <= count_mode ? n_q : free_cnt_q;
            end
        end
    end

    // Strobe: transmission window in normal mode, bare sync mark when triggered or outside normal mode
    always_ff @(posedge clk_sys) begin
        if (rst) strobe_q <= 1'b1;
        else if (!is_normal || trig_mode) strobe_q <= !smp_tick_q;
        else if (xmit) strobe_q <= 1'b0;
        else if (tx_last_bit_done) strobe_q <= 1'b1;
    end

    // Channel reset and synchronise pulse
    always_ff @(posedge clk_sys) begin
        if (rst) sync_q <= 1'b0;
        else sync_q <= mode_d == gos_pkg::MODE_SYNC;
    end

    assign s_axi_awready = aw_rdy_q;
    assign s_axi_wready = w_rdy_q;
    assign s_axi_bvalid = b_vld_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ar_rdy_q;
    assign s_axi_rvalid = r_vld_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign validity_strobe = strobe_q;
    assign sample_strobe = smp_tick_q;
    assign chan_sync = sync_q;
    assign dgram_start = start_q;
    assign dgram = dgram_q;

    // ****************************************
    // Assertions
    // ****************************************
    strobe_fall_a: assert property (@(posedge clk_sys) disable iff (rst)
        (is_normal && !trig_mode && out_due_q) |=> !validity_strobe)
        else $error("strobe did not fall at output tick");
    strobe_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
        (is_normal && !trig_mode && !xmit && tx_last_bit_done) |=> validity_strobe)
        else $error("strobe did not rise after last bit");
    trig_strobe_a: assert property (@(posedge clk_sys) disable iff (rst)
        (trig_mode && !smp_tick_q) |=> validity_strobe)
        else $error("strobe marked a transmission in trigger mode");
    init_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
        !rst_s2_q |=> mode_q == gos_pkg::MODE_SETTLE)
        else $error("external reset did not force init");
    special_order_a: assert property (@(posedge clk_sys) disable iff (rst)
        (spec_start && spec_idx_q == 2'h0) |=> dgram_start && dgram.kind == gos_pkg::KIND_PART)
        else $error("first special datagram is not part number");
    never_suppress_a: assert property (@(posedge clk_sys) disable iff (rst)
        xmit |=> dgram_start && dgram.kind == gos_pkg::KIND_MEAS)
        else $error("measurement datagram suppressed");
    startup_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        (mode_q == gos_pkg::MODE_SPECIAL && mode_d == gos_pkg::MODE_NORMAL && !init_req)
        |=> startup_q ##1 (startup_q || !is_normal))
        else $error("start-up flag not held on entry from init");
    service_exit_a: assert property (@(posedge clk_sys) disable iff (rst)
        (mode_q == gos_pkg::MODE_SERVICE && cmd_exit_norm && !init_req)
        |=> is_normal && !startup_q)
        else $error("service exit set the start-up flag");
    counter_step_a: assert property (@(posedge clk_sys) disable iff (rst)
        (smp_tick_q && mode_q != gos_pkg::MODE_SYNC) |=> free_cnt_q == $past(free_cnt_q) + 8'h01)
        else $error("sample counter did not advance by one");
endmodule : gos_top

// ---- gos_host_model.sv ----
// Host-side model: times each datagram and flags its last bit
`timescale 1ns/100ps
module gos_host_model #(parameter int unsigned TX_CYC = 6) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link
    input wire logic dgram_start,
    input wire gos_pkg::gos_dgram_t dgram,
    output logic tx_last_bit_done,
    // Host view of received data
    output int unsigned valid_cnt,
    output logic [7:0] status_seen
);
    int unsigned cnt_q;
    // Serial time of one datagram
    always_ff @(posedge clk_sys) begin
        tx_last_bit_done <= !rst && cnt_q == 1;
        if (rst || dgram_start) cnt_q <= rst ? 0 : TX_CYC;
        else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
    // Every measurement status byte is read; start-up data is not counted as valid
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            valid_cnt <= 0;
            status_seen <= 8'h00;
        end else if (dgram_start && dgram.kind == gos_pkg::KIND_MEAS) begin
            status_seen <= status_seen | dgram.status;
            if (!dgram.status[6]) valid_cnt <= valid_cnt + 1;
        end
    end
endmodule : gos_host_model

// ---- testbench.sv ----
// Testbench of the gyro output sequencer
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, ext_n = 1'b1, trg = 1'b1;
    logic brd = 1'b0, rrd = 1'b0;
    logic awr, wrd, bv, arr, rv, vs, dst, done, ss, cs;
    logic [7:0] hst;
    int unsigned hv;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd, rdat;
    logic [1:0] br, rr, rrs;
    gos_pkg::gos_sample_t smp;
    gos_pkg::gos_dgram_t dg;
    int fail_count = 0, checked = 0, cyc = 0, cnt, ctr, smps = 0, syncs = 0;
    gos_top #(.SMP_CYC_P(20), .SETTLE_CYC_P(8), .STARTUP_CYC_P(50)) gos_top_i (
        .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rrd), .external_reset_n(ext_n),
        .sample_request_input(trg), .validity_strobe(vs), .sample_in(smp), .sample_strobe(ss),
        .chan_sync(cs), .dgram_start(dst), .dgram(dg), .tx_last_bit_done(done));
    gos_host_model gos_host_model_i (.clk_sys(clk_sys), .rst(rst), .dgram_start(dst),
        .dgram(dg), .tx_last_bit_done(done), .valid_cnt(hv), .status_seen(hst));
    // Sample tick and channel sync pulse counters
    always @(posedge clk_sys) begin
        if (!rst) begin
            smps <= smps + ss;
            syncs <= syncs + cs;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // Bus cycles and datagram wait
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        chk("bresp", br, gos_pkg::RESP_OKAY);
        brd <= 1'b0;
        @(posedge clk_sys);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rd = rdat;
        rr = rrs;
        rrd <= 1'b0;
        @(posedge clk_sys);
    endtask : rd_reg
    task automatic dgw;
        do @(posedge clk_sys); while (!dst);
    endtask : dgw
    initial forever #5 clk_sys = ~clk_sys;
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        smp = {24'h00_007D, 24'h00_0002, 24'h12_3456, 16'h0000, 16'h0000, 16'h1900, 8'h80};
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (int k = 1; k < 4; k++) begin
            dgw();
            chk("kind", 32'(dg.kind), k);
            chk("len", dg.len, k == 1 ? gos_pkg::LEN_PART
                : k == 2 ? gos_pkg::LEN_SERIAL : gos_pkg::LEN_CONFIG);
        end
        wr_reg(gos_pkg::REG_CFG, 32'h0000_0100);
        dgw();
        chk("strobe", vs, 0);
        chk("startup", dg.status[6], 1);
        chk("integrity", dg.status[7], 1);
        chk("rate", dg.value[0], 32'h0012_3456);
        chk("temp", dg.temp[0], 32'h0000_1900);
        cnt = dg.counter;
        do @(posedge clk_sys); while (!done);
        @(posedge clk_sys);
        chk("strobe", vs, 1);
        dgw();
        chk("counter", dg.counter, 8'(cnt + 1));
        rd_reg(8'h40);
        chk("rresp", rr, gos_pkg::RESP_SLVERR);
        rd_reg(gos_pkg::REG_STAT);
        chk("mode", rd[2:0], 3);
        repeat (60) @(posedge clk_sys);
        dgw();
        chk("startup", dg.status[6], 0);
        wr_reg(gos_pkg::REG_CFG, 32'h0000_0104);
        repeat (30) @(posedge clk_sys);
        trg <= 1'b0;
        cnt = 0;
        repeat (40) begin
            @(posedge clk_sys);
            cnt += dst;
        end
        chk("trig", cnt, 1);
        trg <= 1'b1;
        ext_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        ext_n <= 1'b1;
        dgw();
        chk("kind", 32'(dg.kind), 1);
        dgw();
        dgw();
        do @(posedge clk_sys); while (!done);
        // Service entry keeps the start-up flag; direct return skips the start-up period
        wr_reg(gos_pkg::REG_CTRL, 32'h0000_0002);
        rd_reg(gos_pkg::REG_STAT);
        chk("mode", rd[2:0], 4);
        chk("startup", rd[14], 1);
        wr_reg(gos_pkg::REG_CTRL, 32'h0000_0008);
        rd_reg(gos_pkg::REG_STAT);
        chk("mode", rd[2:0], 3);
        chk("startup", rd[14], 0);
        // Z axis at 125 counts gives 8 angle counts per sample
        wr_reg(gos_pkg::REG_CFG, 32'h0000_0201);
        dgw();
        dgw();
        chk("increment", dg.value[2], 32'h0000_0010);
        chk("samples", dg.counter, 2);
        wr_reg(gos_pkg::REG_CFG, 32'h0000_0203);
        dgw();
        cnt = dg.value[2];
        ctr = dg.counter;
        dgw();
        chk("angle", dg.value[2], 24'(cnt + 16));
        chk("counter", dg.counter, 8'(ctr + 2));
        // Filter settles at 118 for a steady 125 input
        wr_reg(gos_pkg::REG_CFG, 32'h0000_0202);
        cnt = smps;
        repeat (600) @(posedge clk_sys);
        chk("ticks", smps - cnt, 30);
        dgw();
        chk("average", dg.value[2], 32'h0000_0076);
        // Reset command, then service exit to init
        wr_reg(gos_pkg::REG_CTRL, 32'h0000_0001);
        rd_reg(gos_pkg::REG_STAT);
        chk("mode", rd[2:0], 0);
        repeat (3) dgw();
        do @(posedge clk_sys); while (!done);
        wr_reg(gos_pkg::REG_CTRL, 32'h0000_0002);
        wr_reg(gos_pkg::REG_CTRL, 32'h0000_0004);
        rd_reg(gos_pkg::REG_STAT);
        chk("mode", rd[2:0], 0);
        dgw();
        chk("kind", 32'(dg.kind), 1);
        chk("syncs", syncs, 4);
        chk("valid", 32'(hv != 0), 1);
        chk("status", hst[7], 1);
        complete_run();
    end
endmodule : testbench
